// *** inc/swf_pkg.sv ***
package swf_pkg;
	// register byte offsets on the bus
	localparam logic [7:0] ADDR_SUMMARY = 8'h00;
	localparam logic [7:0] ADDR_COLL = 8'h04;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;
	localparam logic [7:0] ADDR_LINK_EN = 8'h10;
	localparam logic [7:0] ADDR_EXT0 = 8'h20;
	localparam logic [7:0] ADDR_CNT0 = 8'h40;
	// bit positions in the warning summary word
	localparam int BIT_BACKUP = 1;
	localparam int BIT_ABN = 3;
	localparam int BIT_TASK = 4;
	localparam int BIT_BAT = 5;
	localparam int BIT_EXT = 6;
	localparam int BIT_LINK0 = 8;
	localparam logic [15:0] SUMMARY_USED = 16'h0f7a;
	localparam logic [15:0] SUMMARY_RESET = 16'h0000;
	localparam int N_TASKS = 8;
	localparam int N_LINKS = 4;
	localparam int EXT_WORDS = 4;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : swf_pkg

// *** verilog/swf_task_slot.sv ***
`timescale 1ns/1ns
`default_nettype none
module swf_task_slot
	import swf_pkg::*;
#(
	parameter int CNT_W = 16
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic request,
	input wire logic served,
	input wire logic clear_flag,
	output logic collided,
	output logic [CNT_W-1:0] count
);
	logic busy;
	wire hit = request & busy & ~served;
	wire next_busy = request | (busy & ~served);
	wire next_collided = hit | (collided & ~clear_flag);
	wire at_max = &count;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			busy <= 1'b0;
			collided <= 1'b0;
			count <= '0;
		end else begin
			busy <= next_busy;
			collided <= next_collided;
			if (hit && !at_max)
				count <= count + 1'b1;
		end
	end

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	coll_flag_a: assert property (request && busy && !served |=> collided)
		else $error("collision not flagged");
	coll_count_a: assert property (request && busy && !served && !(&count) |=> count == $past(count) + 1'b1)
		else $error("collision counter did not step");
	count_hold_a: assert property (!(request && busy && !served) |=> $stable(count))
		else $error("collision counter moved without collision");
endmodule : swf_task_slot
`default_nettype wire

// *** verilog/swf_warning_word.sv ***
// Overview of operation
// - one 16-bit summary word carries a bit for each warning at positions 1, 3, 4, 5, 6 and 8 to 11, with 0, 2, 7 and 12 to 15 unused.
// - the abnormal-shutdown bit sets when a halt during power-fail recovery is followed by a cold restart.
// - the abnormal-shutdown bit stays visible during the initialization program and clears when it completes.
// - a halt by the emergency halt function sets up the abnormal-shutdown bit exactly as a power-loss halt does.
// - the task-collision bit sets whenever a task is requested again before its earlier request was served.
// - the battery bit sets while the monitor reports the backup battery below its threshold.
// - the external warning bit sets when user logic records a fault in the external warning bitmap.
// - each of the four link parameter error bits sets while its link is enabled and its parameters are invalid.
// - a link parameter error bit clears when its link is disabled.
// - a request for a task that is executing or pending is a collision, recorded in an eight-entry bitmap.
// - each of the eight tasks has its own counter of collisions.
`timescale 1ns/1ns
`default_nettype none
module swf_warning_word
	import swf_pkg::*;
#(
	parameter int CNT_W = 16
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic backup_data_fault,
	input wire logic power_fail_halt,
	input wire logic emergency_halt_function,
	input wire logic cold_restart,
	input wire logic init_done,
	input wire logic battery_low_pin,
	input wire logic [N_TASKS-1:0] task_request,
	input wire logic [N_TASKS-1:0] task_served,
	input wire logic [N_LINKS-1:0] link_param_invalid,
	output logic [15:0] warning_summary_word,
	output logic irq
);
	generate
		if (CNT_W < 2 || CNT_W > 32) begin : g_bad_cnt
			$error("CNT_W must lie in 2..32");
		end
	endgenerate

	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = a == ADDR_SUMMARY || a == ADDR_COLL || a == ADDR_IRQ_STAT || a == ADDR_IRQ_MASK
			|| a == ADDR_LINK_EN || a[7:4] == ADDR_EXT0[7:4] || a[7:5] == ADDR_CNT0[7:5];
	endfunction : is_mapped

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] st);
		merge = old;
		for (int b = 0; b < 4; b++) begin
			if (st[b])
				merge[8*b +: 8] = wd[8*b +: 8];
		end
	endfunction : merge

	// write channel capture; address and data may come in either order
	logic aw_held, w_held;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	wire aw_take = s_axi_awvalid & s_axi_awready;
	wire w_take = s_axi_wvalid & s_axi_wready;
	wire do_write = aw_held & w_held & ~s_axi_bvalid;
	wire next_aw_held = (aw_held & ~do_write) | aw_take;
	wire next_w_held = (w_held & ~do_write) | w_take;
	wire [7:0] wa = {aw_addr[7:2], 2'h0};
	wire wr_coll = do_write & (wa == ADDR_COLL);
	wire wr_stat = do_write & (wa == ADDR_IRQ_STAT);
	wire wr_mask = do_write & (wa == ADDR_IRQ_MASK);
	wire wr_link = do_write & (wa == ADDR_LINK_EN);
	wire wr_ext = do_write & (wa[7:4] == ADDR_EXT0[7:4]);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
		end else begin
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			s_axi_awready <= ~next_aw_held;
			s_axi_wready <= ~next_w_held;
			if (aw_take)
				aw_addr <= s_axi_awaddr;
			if (w_take) begin
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= is_mapped(wa) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// software-owned state
	logic [15:0] irq_mask, irq_status;
	logic [N_LINKS-1:0] link_enable;
	logic [31:0] ext_map [EXT_WORDS];
	wire [31:0] mask_merged = merge({16'h0000, irq_mask}, w_data, w_strb);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_mask <= 16'h0000;
			link_enable <= '0;
			for (int i = 0; i < EXT_WORDS; i++)
				ext_map[i] <= 32'h0000_0000;
		end else begin
			if (wr_mask)
				irq_mask <= mask_merged[15:0] & SUMMARY_USED;
			if (wr_link)
				link_enable <= w_strb[0] ? w_data[N_LINKS-1:0] : link_enable;
			if (wr_ext)
				ext_map[wa[3:2]] <= merge(ext_map[wa[3:2]], w_data, w_strb);
		end
	end

	// battery pin comes from the analog monitor, so it is synchronised first
	logic bat_meta, bat_sync;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bat_meta <= 1'b0;
			bat_sync <= 1'b0;
		end else begin
			bat_meta <= battery_low_pin;
			bat_sync <= bat_meta;
		end
	end

	// halt is remembered until the next restart decides what it meant
	logic halt_seen, abn_flag;
	wire halt_now = power_fail_halt | emergency_halt_function;
	wire abn_set = cold_restart & halt_seen;
	wire next_halt_seen = halt_now | (halt_seen & ~cold_restart);
	wire next_abn_flag = abn_set | (abn_flag & ~init_done);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			halt_seen <= 1'b0;
			abn_flag <= 1'b0;
		end else begin
			halt_seen <= next_halt_seen;
			abn_flag <= next_abn_flag;
		end
	end

	// per-task collision trackers
	logic [N_TASKS-1:0] coll_bitmap;
	logic [CNT_W-1:0] coll_count [N_TASKS];
	wire [N_TASKS-1:0] coll_clear = wr_coll && w_strb[0] ? w_data[N_TASKS-1:0] : '0;

	for (genvar t = 0; t < N_TASKS; t++) begin : g_task
		swf_task_slot #(
			.CNT_W(CNT_W)
		) u_slot (
			.aclk(aclk),
			.aresetn(aresetn),
			.request(task_request[t]),
			.served(task_served[t]),
			.clear_flag(coll_clear[t]),
			.collided(coll_bitmap[t]),
			.count(coll_count[t])
		);
	end

	// summary word assembly
	wire ext_any = |{ext_map[0], ext_map[1], ext_map[2], ext_map[3]};
	wire [N_LINKS-1:0] link_fault = link_enable & link_param_invalid;
	logic [15:0] next_summary;

	always_comb begin
		next_summary = 16'h0000;
		next_summary[BIT_BACKUP] = backup_data_fault;
		next_summary[BIT_ABN] = abn_flag;
		next_summary[BIT_TASK] = |coll_bitmap;
		next_summary[BIT_BAT] = bat_sync;
		next_summary[BIT_EXT] = ext_any;
		next_summary[BIT_LINK0 +: N_LINKS] = link_fault;
		next_summary = next_summary & SUMMARY_USED;
	end

	// a new warning is the rising edge of its summary bit; set wins over write-one-to-clear
	wire [15:0] new_events = next_summary & ~warning_summary_word;
	wire [15:0] stat_clear = wr_stat && w_strb[0] ? {8'h00, w_data[7:0]} : 16'h0000;
	wire [15:0] stat_clear_hi = wr_stat && w_strb[1] ? {w_data[15:8], 8'h00} : 16'h0000;
	wire [15:0] next_irq_status = new_events | (irq_status & ~(stat_clear | stat_clear_hi));

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			warning_summary_word <= SUMMARY_RESET;
			irq_status <= 16'h0000;
			irq <= 1'b0;
		end else begin
			warning_summary_word <= next_summary;
			irq_status <= next_irq_status;
			irq <= |(next_irq_status & irq_mask);
		end
	end

	// read channel; data is sampled when the address is taken
	wire [7:0] ra = {s_axi_araddr[7:2], 2'h0};
	wire ar_take = s_axi_arvalid & s_axi_arready;
	wire [31:0] rd_word =
		ra == ADDR_SUMMARY ? {16'h0000, warning_summary_word} :
		ra == ADDR_COLL ? {24'h00_0000, coll_bitmap} :
		ra == ADDR_IRQ_STAT ? {16'h0000, irq_status} :
		ra == ADDR_IRQ_MASK ? {16'h0000, irq_mask} :
		ra == ADDR_LINK_EN ? {28'h000_0000, link_enable} :
		ra[7:4] == ADDR_EXT0[7:4] ? ext_map[ra[3:2]] :
		ra[7:5] == ADDR_CNT0[7:5] ? 32'(coll_count[ra[4:2]]) :
		32'h0000_0000;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end else if (ar_take) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word;
			s_axi_rresp <= is_mapped(ra) ? RESP_OKAY : RESP_SLVERR;
		end else if (!s_axi_rvalid || s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	abn_set_a: assert property (cold_restart && halt_seen |-> ##2 warning_summary_word[BIT_ABN])
		else $error("abnormal shutdown not reported after cold restart");
	abn_clear_a: assert property (init_done && !abn_set |-> ##2 !warning_summary_word[BIT_ABN])
		else $error("abnormal shutdown not cleared at init done");
	emergency_halt_function_arm_a: assert property (emergency_halt_function ##1 cold_restart |-> ##2 warning_summary_word[BIT_ABN])
		else $error("emergency halt did not arm abnormal shutdown");
	task_bit_a: assert property (warning_summary_word[BIT_TASK] == $past(|coll_bitmap))
		else $error("task collision bit does not follow bitmap");
	battery_bit_a: assert property (warning_summary_word[BIT_BAT] == $past(battery_low_pin, 3))
		else $error("battery bit wrong");
	ext_bit_a: assert property (warning_summary_word[BIT_EXT] == $past(ext_any))
		else $error("external warning bit does not follow bitmap");
	link_bits_a: assert property (warning_summary_word[11:8] == $past(link_enable & link_param_invalid))
		else $error("link fault bits wrong");
	link_off_a: assert property (!link_enable[0] |=> !warning_summary_word[BIT_LINK0])
		else $error("link fault bit set while link disabled");
	unused_zero_a: assert property ((warning_summary_word & ~SUMMARY_USED) == 16'h0000)
		else $error("unused summary bit set");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");

	abn_seen_c: cover property (halt_seen ##1 cold_restart ##2 warning_summary_word[BIT_ABN]);
	coll_seen_c: cover property ($rose(|coll_bitmap));
	link_seen_c: cover property ($rose(warning_summary_word[BIT_LINK0 +: N_LINKS] != 4'h0));
	irq_seen_c: cover property ($rose(irq));
endmodule : swf_warning_word
`default_nettype wire

// *** bench/test_system_warning_flag_word.sv ***
`timescale 1ns/1ns
`default_nettype none
module test_system_warning_flag_word;
	import swf_pkg::*;
	logic aclk = 0;
	logic aresetn = 0;
	logic [7:0] awaddr = 0;
	logic [7:0] araddr = 0;
	logic [31:0] wdata = 0;
	logic [3:0] wstrb = 0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid, irq;
	logic [1:0] bresp, rresp, r;
	logic [31:0] rdata, rd_d;
	logic [15:0] word;
	logic bkf = 0, pfh = 0, ehf = 0, cold = 0, idone = 0, bat = 0;
	logic [7:0] treq = 0, tsrv = 0;
	logic [3:0] linv = 0;
	int miscompares = 0, n_checks = 0, cyc = 0;
	swf_warning_word uut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.backup_data_fault(bkf), .power_fail_halt(pfh), .emergency_halt_function(ehf),
		.cold_restart(cold), .init_done(idone), .battery_low_pin(bat),
		.task_request(treq), .task_served(tsrv), .link_param_invalid(linv),
		.warning_summary_word(word), .irq(irq));
	initial begin
		forever #5 aclk = ~aclk;
	end
	// a hang anywhere ends in the same report
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			miscompares++;
			final_report();
		end
	end
	task final_report;
		if (miscompares == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : final_report
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task step(input int n);
		repeat (n) @(posedge aclk);
	endtask : step
	// address and data offered together, each dropped as soon as it is taken
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_done;
		logic w_done;
		aw_done = 0;
		w_done = 0;
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1;
		wvalid <= 1;
		while (!(aw_done && w_done)) begin
			@(posedge aclk);
			if (!aw_done && awready) begin
				aw_done = 1;
				awvalid <= 0;
			end
			if (!w_done && wready) begin
				w_done = 1;
				wvalid <= 0;
			end
		end
		// raised here, not at the start, so back-to-back writes never drive it twice in one step
		bready <= 1;
		do @(posedge aclk); while (bvalid !== 1'b1);
		r = bresp;
		bready <= 0;
	endtask : wr
	task rd(input logic [7:0] a);
		araddr <= a;
		arvalid <= 1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 0;
		rready <= 1;
		do @(posedge aclk); while (rvalid !== 1'b1);
		rd_d = rdata;
		r = rresp;
		rready <= 0;
	endtask : rd
	task rc(input string nm, input logic [7:0] a, input logic [31:0] e);
		rd(a);
		chk(nm, e, rd_d);
	endtask : rc
	task t_map;
		rc("summary", ADDR_SUMMARY, 32'h0);
		wr(ADDR_SUMMARY, 32'hffff_ffff);
		chk("summary write resp", RESP_OKAY, r);
		step(3);
		chk("summary after write", 16'h0000, word);
		wr(8'hfc, 32'h1);
		chk("unmapped write resp", RESP_SLVERR, r);
		rd(8'hf0);
		chk("unmapped read resp", RESP_SLVERR, r);
		bkf <= 1;
		step(3);
		chk("backup bit", 16'h0002, word);
		bkf <= 0;
		step(3);
	endtask : t_map
	task t_abn;
		for (int k = 0; k < 2; k++) begin
			pfh <= (k == 0);
			ehf <= (k == 1);
			step(1);
			pfh <= 0;
			step(3);
			chk("halt only", 16'h0000, word);
			// emergency halt held up to the restart so the arming edge sits right before it
			ehf <= 0;
			cold <= 1;
			step(1);
			cold <= 0;
			step(8);
			chk("abnormal set", 16'h0008, word);
			idone <= 1;
			step(1);
			idone <= 0;
			step(3);
			chk("abnormal cleared", 16'h0000, word);
		end
		cold <= 1;
		step(1);
		cold <= 0;
		step(3);
		chk("cold without halt", 16'h0000, word);
	endtask : t_abn
	task t_coll;
		treq <= 8'h02;
		step(1);
		tsrv <= 8'h02;
		treq <= 8'h04;
		step(1);
		tsrv <= 8'h00;
		treq <= 8'h06;
		step(1);
		treq <= 8'h00;
		step(3);
		chk("collision bit", 16'h0010, word);
		rc("collision map", ADDR_COLL, 32'h4);
		rc("count task2", ADDR_CNT0 + 8'h08, 32'h1);
		rc("count task1", ADDR_CNT0 + 8'h04, 32'h0);
		tsrv <= 8'h06;
		step(1);
		tsrv <= 8'h00;
		wr(ADDR_COLL, 32'hff);
		step(3);
		chk("collision cleared", 16'h0000, word);
	endtask : t_coll
	task t_ext_link;
		bat <= 1;
		step(5);
		chk("battery bit", 16'h0020, word);
		bat <= 0;
		step(5);
		wr(ADDR_EXT0 + 8'h0c, 32'h8000_0000);
		step(3);
		chk("ext warning", 16'h0040, word);
		wr(ADDR_EXT0 + 8'h0c, 32'h0);
		step(3);
		chk("ext cleared", 16'h0000, word);
		linv <= 4'hf;
		step(3);
		chk("links disabled", 16'h0000, word);
		wr(ADDR_LINK_EN, 32'h5);
		step(3);
		chk("link faults", 16'h0500, word);
		wr(ADDR_LINK_EN, 32'h0);
		step(3);
		chk("link faults off", 16'h0000, word);
		linv <= 4'h0;
	endtask : t_ext_link
	task t_irq;
		wr(ADDR_IRQ_STAT, 32'hffff);
		wr(ADDR_IRQ_MASK, 32'hffff);
		rc("mask used bits", ADDR_IRQ_MASK, {16'h0, SUMMARY_USED});
		step(2);
		chk("irq idle", 1'b0, irq);
		bat <= 1;
		step(6);
		chk("irq raised", 1'b1, irq);
		rc("irq status", ADDR_IRQ_STAT, 32'h20);
		wr(ADDR_IRQ_MASK, 32'h0);
		step(2);
		chk("irq masked", 1'b0, irq);
		wr(ADDR_IRQ_MASK, 32'hffff);
		step(2);
		chk("irq unmasked", 1'b1, irq);
		wr(ADDR_IRQ_STAT, 32'h20);
		step(2);
		chk("irq cleared", 1'b0, irq);
		bat <= 0;
	endtask : t_irq
	initial begin
		step(16);
		aresetn <= 1;
		step(2);
		t_map();
		t_abn();
		t_coll();
		t_ext_link();
		t_irq();
		final_report();
	end
endmodule : test_system_warning_flag_word
`default_nettype wire
